// File: common/serial_bus_pkg.sv
// Package: constants and types of the serial bus master and loader
// How it works
// - open-drain lines, 100 Kb/s, seven-bit addresses
// - start: SDA falls while SCL high
// - stop: SDA rises while SCL high
// - SDA steady while SCL high
// - eight-bit bytes, each followed by acknowledge
// - receiver acknowledges by holding SDA low
// - sole master, SCL near 100 kHz, released idle
// - software single bytes; loader reads doublewords
// - write: start, address, W; missing ack flagged
// - then index, data MSB first, ack, stop
// - read: R/W one, master acknowledges bytes
// - after reset with interface detected, load
// - references 01h..04h load 40h/80h/8Ch/90h bits
// - bad image stops load, sets load error
// - loader addresses EEPROM at 1010 000b
// - four data bytes, MSB first, address increments
// - eight-byte records until end-of-list marker
// - select bit picks send-byte over write-byte
// - target write starts; index, data registers
// - status: read valid, busy, errors, select
// - strap pulldown sets flag; detect_clear clears
package serial_bus_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;  // mclk rate
  localparam int SCL_PERIOD_NS = 10000;  // one bit at 100 kHz
  localparam int QUARTER_CYC = SCL_PERIOD_NS * CLK_MHZ / 1000 / 4;
  localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);
  localparam logic [1:0] STRAP_SETTLE = 2'h3;  // sync settle count
  // ----------------------------------------
  // configuration byte offsets and status bits
  // ----------------------------------------
  localparam logic [7:0] OFS_DATA = 8'hB0;
  localparam logic [7:0] OFS_INDEX = 8'hB1;
  localparam logic [7:0] OFS_TARGET = 8'hB2;
  localparam logic [7:0] OFS_CSR = 8'hB3;
  localparam int CSR_NAK = 0;  // no acknowledge, write one clears
  localparam int CSR_ROM_ERR = 1;  // load error, write one clears
  localparam int CSR_SEND_BYTE = 3;  // send_byte_format_select
  localparam int CSR_RD_VALID = 6;
  localparam int CSR_BUSY = 7;
  // ----------------------------------------
  // loader image
  // ----------------------------------------
  localparam logic [6:0] EEPROM_SLAVE = 7'h50;
  localparam logic [7:0] END_OF_LIST_MARKER = 8'hFF;
  localparam logic [7:0] RECORD_STEP = 8'h08;
  localparam logic [2:0] LOAD_BYTES = 3'h5;  // reference plus four
  localparam logic [7:0] REF_SUBSYS = 8'h01;
  localparam logic [7:0] REF_SYSCTL = 8'h02;
  localparam logic [7:0] REF_MFUNC = 8'h03;
  localparam logic [7:0] REF_RETRY = 8'h04;
  localparam logic [7:0] CFG_SUBSYS = 8'h40;
  localparam logic [7:0] CFG_SYSCTL = 8'h80;
  localparam logic [7:0] CFG_MFUNC = 8'h8C;
  localparam logic [7:0] CFG_RETRY = 8'h90;
  localparam logic [31:0] MASK_SUBSYS = 32'hFFFFFFFF;
  localparam logic [31:0] MASK_SYSCTL = 32'hED00C07A;
  localparam logic [31:0] MASK_MFUNC = 32'h0FFFFFFF;
  localparam logic [31:0] MASK_RETRY = 32'h9F4FA0C0;
  // ----------------------------------------
  // byte sequence and states
  // ----------------------------------------
  localparam logic [3:0] STEP_ADDR_W = 4'h0;
  localparam logic [3:0] STEP_INDEX = 4'h1;
  localparam logic [3:0] STEP_DATA = 4'h2;
  localparam logic [3:0] STEP_ADDR_R = 4'h3;
  localparam logic [3:0] ACK_BIT = 4'h8;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_TX, ST_RX, ST_STOP} bus_state_e;
  typedef enum logic [1:0] {JOB_WR, JOB_RD, JOB_LOAD} job_e;
endpackage

// File: hdl/serial_bus_master.sv
// Module: two-wire bus master with config byte port and EEPROM loader
module serial_bus_master (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // configuration byte port
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // strap pin and detect flag
  input wire logic latch_strap,
  input wire logic detect_clear,
  output logic interface_detected_flag,
  // clock line
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  // data line
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // register default loads
  output logic load_strobe,
  output logic [7:0] load_offset,
  output logic [31:0] load_value,
  output logic [31:0] load_mask
);
  import serial_bus_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    bus_state_e st;
    logic [1:0] q;  // quarter of the bit
    logic [7:0] tick;  // cycles in quarter
    logic [3:0] bitn;  // bit of byte, 8 = ack
    logic [3:0] step;  // byte in sequence
    job_e job;
    logic [7:0] sh;  // shift register
    logic [2:0] rxleft;  // bytes still to receive
    logic restart;  // repeated start
    logic ack_bad;  // sampled ack was high
    logic scl_low;
    logic sda_low;
    logic [7:0] data;
    logic [7:0] index;
    logic [7:0] target;
    logic send_byte;
    logic err_nak;
    logic err_rom;
    logic rd_valid;
    logic [7:0] waddr;  // record word address
    logic [23:0] acc;  // upper data bytes
    logic load_stb;
    logic [7:0] ld_ofs;
    logic [31:0] ld_val;
    logic [31:0] ld_mask;
    logic [1:0] boot;  // counts to strap capture
    logic iface_en;
    logic detected;
    logic load_req;  // record pending
    logic [7:0] rdata;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] strap_sync;
  } state_s;

  state_s state_reg;  // all flops but the check counter
  state_s state_next;  // their next value
  logic stretch;  // slave holds clock low
  logic q_end;  // last cycle of a quarter
  logic bit_end;  // last cycle of a bit
  logic idle;  // free for a new transfer
  logic busy;  // status busy bit
  logic capture;  // strap sampling cycle
  logic [7:0] csr_now;  // live status byte
  logic [39:0] rec_now;  // offset and mask of sh

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte sent at the current step
  function automatic logic [7:0] tx_byte(input state_s s);
    logic [6:0] a7;
    a7 = (s.job == JOB_LOAD) ? EEPROM_SLAVE : s.target[7:1];
    case (s.step)
      STEP_ADDR_W: tx_byte = {a7, 1'b0};
      STEP_INDEX: tx_byte = (s.job == JOB_LOAD) ? s.waddr : s.index;
      STEP_DATA: tx_byte = s.data;
      default: tx_byte = {a7, 1'b1};
    endcase
  endfunction

  // target offset and loadable bits; zero offset means bad reference
  function automatic logic [39:0] record_of(input logic [7:0] r);
    case (r)
      REF_SUBSYS: record_of = {CFG_SUBSYS, MASK_SUBSYS};
      REF_SYSCTL: record_of = {CFG_SYSCTL, MASK_SYSCTL};
      REF_MFUNC: record_of = {CFG_MFUNC, MASK_MFUNC};
      REF_RETRY: record_of = {CFG_RETRY, MASK_RETRY};
      default: record_of = '0;
    endcase
  endfunction

  // ----------------------------------------
  // decoded conditions
  // ----------------------------------------
  // hold a high quarter while the line still reads low
  assign stretch = state_reg.st != ST_IDLE && state_reg.q[1] && !state_reg.scl_sync[1];
  assign q_end = state_reg.st != ST_IDLE && !stretch && state_reg.tick == QUARTER_LAST;
  assign bit_end = q_end && state_reg.q == 2'h3;
  assign idle = state_reg.st == ST_IDLE && !state_reg.load_req;
  assign busy = !idle;
  assign capture = state_reg.boot == STRAP_SETTLE - 2'h1;
  assign rec_now = record_of(state_reg.sh);

  // status byte as software reads it
  always_comb begin
    csr_now = '0;
    csr_now[CSR_NAK] = state_reg.err_nak;
    csr_now[CSR_ROM_ERR] = state_reg.err_rom;
    csr_now[CSR_SEND_BYTE] = state_reg.send_byte;
    csr_now[CSR_RD_VALID] = state_reg.rd_valid;
    csr_now[CSR_BUSY] = busy;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.load_stb = 1'b0;
    // pins cross into mclk through two flops
    state_next.scl_sync = {state_reg.scl_sync[0], scl_i};
    state_next.sda_sync = {state_reg.sda_sync[0], sda_i};
    state_next.strap_sync = {state_reg.strap_sync[0], latch_strap};
    // strap caught once, after the sync has filled
    if (state_reg.boot != STRAP_SETTLE) begin
      state_next.boot = state_reg.boot + 2'h1;
    end
    if (detect_clear) begin
      state_next.detected = 1'b0;
    end
    // set after clear: a set in the clear cycle wins
    if (capture && !state_reg.strap_sync[1]) begin
      state_next.detected = 1'b1;
      state_next.iface_en = 1'b1;
      state_next.load_req = 1'b1;
    end
    // quarter timer
    if (state_reg.st == ST_IDLE || q_end) begin
      state_next.tick = '0;
    end else if (!stretch) begin
      state_next.tick = state_reg.tick + 8'h01;
    end
    if (q_end) begin
      state_next.q = state_reg.q + 2'h1;
    end
    // registered read data
    case (cfg_addr)
      OFS_DATA: state_next.rdata = state_reg.data;
      OFS_INDEX: state_next.rdata = state_reg.index;
      OFS_TARGET: state_next.rdata = state_reg.target;
      OFS_CSR: state_next.rdata = csr_now;
      default: state_next.rdata = 8'h00;  // nothing else decoded
    endcase
    // software writes
    if (cfg_wr) begin
      case (cfg_addr)
        OFS_DATA: state_next.data = cfg_wdata;
        OFS_INDEX: state_next.index = cfg_wdata;
        OFS_TARGET: begin
          // ignored while busy or before detection
          if (idle && state_reg.iface_en) begin
            state_next.target = cfg_wdata;
            state_next.job = cfg_wdata[0] ? JOB_RD : JOB_WR;
            state_next.rd_valid = 1'b0;
            state_next.st = ST_START;
            state_next.step = STEP_ADDR_W;
            state_next.restart = 1'b0;
          end
        end
        OFS_CSR: begin
          state_next.send_byte = cfg_wdata[CSR_SEND_BYTE];
          if (cfg_wdata[CSR_NAK]) begin
            state_next.err_nak = 1'b0;
          end
          if (cfg_wdata[CSR_ROM_ERR]) begin
            state_next.err_rom = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // loader fetches the next record
    if (state_reg.st == ST_IDLE && state_reg.load_req) begin
      state_next.load_req = 1'b0;
      state_next.job = JOB_LOAD;
      state_next.st = ST_START;
      state_next.step = STEP_ADDR_W;
      state_next.restart = 1'b0;
    end
    // sample the data line in the middle of the high phase, at the end of quarter 2
    if (q_end && state_reg.q == 2'h2) begin
      if (state_reg.bitn == ACK_BIT) begin
        state_next.ack_bad = state_reg.sda_sync[1];
      end else if (state_reg.st == ST_RX) begin
        state_next.sh = {state_reg.sh[6:0], state_reg.sda_sync[1]};
      end
    end
    // bit and byte sequencing
    if (bit_end) begin
      case (state_reg.st)
        ST_START: begin
          state_next.st = ST_TX;
          state_next.bitn = '0;
          state_next.sh = tx_byte(state_reg);
        end
        ST_TX: begin
          if (state_reg.bitn != ACK_BIT) begin
            state_next.bitn = state_reg.bitn + 4'h1;
            state_next.sh = {state_reg.sh[6:0], 1'b0};
          end else begin
            state_next.bitn = '0;
            if (state_reg.ack_bad) begin
              state_next.st = ST_STOP;
              if (state_reg.job == JOB_LOAD) begin
                state_next.err_rom = 1'b1;
              end else begin
                state_next.err_nak = 1'b1;
              end
            end else begin
              case (state_reg.step)
                STEP_ADDR_W: begin
                  // send-byte skips the index byte
                  state_next.step = (state_reg.job == JOB_WR && state_reg.send_byte) ?
                                    STEP_DATA : STEP_INDEX;
                end
                STEP_INDEX: begin
                  if (state_reg.job == JOB_WR) begin
                    state_next.step = STEP_DATA;
                  end else begin
                    state_next.st = ST_START;
                    state_next.restart = 1'b1;
                    state_next.step = STEP_ADDR_R;
                  end
                end
                STEP_DATA: state_next.st = ST_STOP;
                default: begin
                  state_next.st = ST_RX;
                  state_next.rxleft = (state_reg.job == JOB_LOAD) ? LOAD_BYTES : 3'h1;
                end
              endcase
              if (state_next.st == ST_TX) begin
                state_next.sh = tx_byte(state_next);
              end
            end
          end
        end
        ST_RX: begin
          if (state_reg.bitn != ACK_BIT) begin
            state_next.bitn = state_reg.bitn + 4'h1;
          end else begin
            state_next.bitn = '0;
            state_next.rxleft = state_reg.rxleft - 3'h1;
            if (state_reg.job == JOB_RD) begin
              state_next.data = state_reg.sh;
              state_next.rd_valid = 1'b1;
              state_next.st = ST_STOP;
            end else if (state_reg.rxleft == LOAD_BYTES) begin
              // reference byte: marker ends, unknown fails
              if (state_reg.sh == END_OF_LIST_MARKER) begin
                state_next.st = ST_STOP;
              end else if (rec_now[39:32] == 8'h00) begin
                state_next.st = ST_STOP;
                state_next.err_rom = 1'b1;
              end else begin
                state_next.ld_ofs = rec_now[39:32];
                state_next.ld_mask = rec_now[31:0];
              end
            end else if (state_reg.rxleft != 3'h1) begin
              state_next.acc = {state_reg.acc[15:0], state_reg.sh};
            end else begin
              state_next.st = ST_STOP;
              state_next.load_stb = 1'b1;
              state_next.ld_val = {state_reg.acc, state_reg.sh};
              state_next.waddr = state_reg.waddr + RECORD_STEP;
              // running off the end of the image is a format error
              if (8'(state_reg.waddr + RECORD_STEP) == 8'h00) begin
                state_next.err_rom = 1'b1;
              end else begin
                state_next.load_req = 1'b1;
              end
            end
          end
        end
        ST_STOP: state_next.st = ST_IDLE;
        default: state_next.st = ST_IDLE;
      endcase
    end
    // line drive; clock low in quarters 0 and 1, high through a first start
    case (state_next.st)
      ST_START: state_next.scl_low = state_next.restart && !state_next.q[1];
      ST_TX, ST_RX, ST_STOP: state_next.scl_low = !state_next.q[1];
      default: state_next.scl_low = 1'b0;
    endcase
    // data bits move only in quarter 1, a quarter after the clock fell; start and stop edges move in quarter 3
    if (state_next.st == ST_IDLE) begin
      state_next.sda_low = 1'b0;
    end else if (state_next.q != 2'h0) begin
      case (state_next.st)
        ST_START: state_next.sda_low = state_next.q == 2'h3;
        ST_TX: state_next.sda_low = state_next.bitn != ACK_BIT && !state_next.sh[7];
        ST_RX: state_next.sda_low = state_next.bitn == ACK_BIT;
        default: state_next.sda_low = state_next.q != 2'h3;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // open-drain: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = state_reg.scl_low;
  assign sda_oe = state_reg.sda_low;
  assign cfg_rdata = state_reg.rdata;
  assign interface_detected_flag = state_reg.detected;
  assign load_strobe = state_reg.load_stb;
  assign load_offset = state_reg.ld_ofs;
  assign load_value = state_reg.ld_val;
  assign load_mask = state_reg.ld_mask;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [9:0] low_cnt_reg;  // cycles scl held low
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt_reg <= '0;
    end else begin
      low_cnt_reg <= scl_oe ? low_cnt_reg + 10'h001 : 10'h000;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence sw_launch;
    cfg_wr && cfg_addr == OFS_TARGET && idle && state_reg.iface_en;
  endsequence
  sequence rx_ref_done;
    bit_end && state_reg.st == ST_RX && state_reg.bitn == ACK_BIT && state_reg.job == JOB_LOAD
      && state_reg.rxleft == LOAD_BYTES;
  endsequence

  a_start_edge: assert property ($rose(sda_oe) && !scl_oe |-> state_reg.st == ST_START)
    else $error("data fell with clock high outside a start");
  a_stop_edge: assert property ($fell(sda_oe) && !scl_oe |-> state_reg.st == ST_STOP)
    else $error("data rose with clock high outside a stop");
  a_sda_stable: assert property (!scl_oe && !$past(scl_oe) && state_reg.st inside {ST_TX, ST_RX}
    |-> $stable(sda_oe))
    else $error("data moved during clock high");
  a_scl_low_len: assert property ($fell(scl_oe) |-> low_cnt_reg == 10'(2 * QUARTER_CYC))
    else $error("clock low phase has wrong length");
  a_idle_release: assert property (state_reg.st == ST_IDLE [*2] |-> !scl_oe && !sda_oe)
    else $error("lines driven while idle");
  a_sw_start: assert property (sw_launch |=> busy && state_reg.st == ST_START ##1 busy)
    else $error("target write did not start a transfer");
  a_nak_flag: assert property (bit_end && state_reg.st == ST_TX && state_reg.bitn == ACK_BIT
    && state_reg.ack_bad && state_reg.job != JOB_LOAD |=> state_reg.err_nak && state_reg.st == ST_STOP)
    else $error("missing acknowledge not flagged");
  a_bad_ref: assert property (rx_ref_done ##0 (rec_now[39:32] == 8'h00 && state_reg.sh != END_OF_LIST_MARKER)
    |=> state_reg.err_rom && state_reg.st == ST_STOP)
    else $error("bad reference did not stop the load");
  a_master_ack: assert property (state_reg.st == ST_RX && state_reg.bitn == ACK_BIT && state_reg.q[1]
    |-> sda_oe)
    else $error("received byte not acknowledged");
  a_strap_load: assert property (capture && !state_reg.strap_sync[1]
    |=> interface_detected_flag && state_reg.load_req ##1 state_reg.job == JOB_LOAD)
    else $error("strap did not start the loader");
endmodule  // serial_bus_master

// File: verification/serial_slave_model.sv
// partner model: behavioural two-wire slave holding a byte memory
module serial_slave_model #(
  parameter logic [6:0] ADDR = 7'h52
) (
  // wire levels
  input wire logic scl,
  input wire logic sda,
  // high pulls the data line low
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] mem [256];  // byte store
  logic [7:0] b;  // last byte seen
  logic [7:0] ptr;  // word pointer
  logic brk;  // start or stop seen mid-byte
  logic again;  // repeated start seen
  // ----------------------------------------
  // bit level helpers
  // ----------------------------------------
  // sample at scl rise; a change late in the high phase is a start or stop
  task automatic get_byte(output logic [7:0] v, output logic k);
    k = 1'b0;
    for (int i = 0; i < 8 && !k; i++) begin
      @(posedge scl);
      v = {v[6:0], sda};
      #3000;
      k = (sda !== v[0]);
    end
  endtask
  // hold low over the whole ninth high phase, change only while scl low
  task automatic give_ack();
    @(negedge scl);
    #200 sda_pull = 1'b1;
    @(negedge scl);
    #200 sda_pull = 1'b0;
  endtask
  // ----------------------------------------
  // transaction flow
  // ----------------------------------------
  // other addresses are left unanswered, as an absent device would
  initial begin
    sda_pull = 1'b0;
    // a well-formed image: references ascend, the marker closes the list
    for (int k = 0; k < 4; k++) mem[8 * k] = 8'(k + 1);
    mem[32] = 8'hFF;
    forever begin
      @(negedge sda iff scl === 1'b1);
      again = 1'b1;
      while (again) begin
        again = 1'b0;
        get_byte(b, brk);
        if (!brk && b[7:1] == ADDR) begin
          give_ack();
          if (b[0]) begin
            // drive read bits msb first, release before master ack
            for (int i = 7; i >= 0; i--) begin
              sda_pull = !mem[ptr][i];
              @(negedge scl);
              #200;
            end
            sda_pull = 1'b0;
            ptr = ptr + 8'h01;
          end else begin
            get_byte(ptr, brk);
            if (!brk) give_ack();
            get_byte(b, brk);
            again = brk && sda === 1'b0;
            if (!brk) begin
              mem[ptr] = b;
              give_ack();
            end
          end
        end
      end
    end
  end
endmodule  // serial_slave_model

// File: verification/test_serial_bus_master.sv
// testbench: register driven transfers against a slave model
module test_serial_bus_master;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_bus_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic cfg_wr = 1'b0;
  logic [7:0] cfg_addr = OFS_CSR;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic latch_strap = 1'b0;  // pulldown fitted
  logic detect_clear = 1'b0;
  logic interface_detected_flag, scl_o, scl_oe, sda_o, sda_oe, load_strobe, sda_pull;
  logic [7:0] load_offset;
  logic [31:0] load_value, load_mask;
  wire scl = !scl_oe;  // pull-up; only the master drives it
  wire sda = !(sda_oe | sda_pull);  // wired and of both parties
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  int strobes = 0;
  logic [7:0] rd;
  // ----------------------------------------
  // design and partner
  // ----------------------------------------
  serial_bus_master serial_bus_master_inst (
    .mclk(mclk), .reset_n(reset_n), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .latch_strap(latch_strap), .detect_clear(detect_clear),
    .interface_detected_flag(interface_detected_flag), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .load_strobe(load_strobe), .load_offset(load_offset),
    .load_value(load_value), .load_mask(load_mask));
  // no device answers the loader address, so the load must fail
  serial_slave_model #(.ADDR(7'h52)) serial_slave_model_inst (.scl(scl), .sda(sda), .sda_pull(sda_pull));
  always #5 mclk = !mclk;
  // cycle count, strobe count and hang limit
  always @(posedge mclk) begin
    cycles++;
    if (load_strobe === 1'b1) strobes++;
    if (cycles == 100000) begin
      failures++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // one-cycle write strobe, inputs moved just after the edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge mclk);
    #1;
    cfg_wr = 1'b0;
  endtask
  // read data is registered, so let two edges pass
  task automatic reg_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    #1;
    cfg_addr = a;
    repeat (2) @(posedge mclk);
    #1;
    rd = cfg_rdata;
    if (what != "") check(what, exp, rd);
  endtask
  // bounded poll of the busy bit
  task automatic wait_idle();
    rd = 8'h80;
    for (int i = 0; i < 20000 && rd[7] !== 1'b0; i++) reg_chk("", OFS_CSR, 8'h00);
    check("busy clear", 8'h00, {rd[7], 7'h00});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    check("detect flag", 8'h01, {7'h00, interface_detected_flag});
    check("drive levels", 8'h00, {6'h00, scl_o, sda_o});
    reg_chk("busy at load", OFS_CSR, 8'h80);
    wait_idle();
    reg_chk("load error", OFS_CSR, 8'h02);
    check("lines released", 8'h00, {6'h00, scl_oe, sda_oe});
    reg_wr(OFS_CSR, 8'h02);
    reg_chk("error cleared", OFS_CSR, 8'h00);
    // write to an absent slave
    reg_wr(OFS_INDEX, 8'h05);
    reg_wr(OFS_DATA, 8'hA5);
    reg_wr(OFS_TARGET, 8'hA6);
    wait_idle();
    reg_chk("no ack", OFS_CSR, 8'h01);
    reg_wr(OFS_CSR, 8'h09);
    reg_chk("select bit", OFS_CSR, 8'h08);
    reg_wr(OFS_CSR, 8'h00);
    // byte write, with a second start refused while busy
    reg_wr(OFS_TARGET, 8'hA4);
    reg_wr(OFS_TARGET, 8'hA6);
    reg_chk("target kept", OFS_TARGET, 8'hA4);
    reg_chk("busy in write", OFS_CSR, 8'h80);
    wait_idle();
    reg_chk("write status", OFS_CSR, 8'h00);
    check("slave byte", 8'hA5, serial_slave_model_inst.mem[5]);
    // byte read back into the data register
    reg_wr(OFS_DATA, 8'h00);
    reg_wr(OFS_TARGET, 8'hA5);
    wait_idle();
    reg_chk("read valid", OFS_CSR, 8'h40);
    reg_chk("read data", OFS_DATA, 8'hA5);
    check("load strobes", 8'h00, 8'(strobes));
    // a failed load must leave the default outputs untouched
    check("load offset", 8'h00, load_offset);
    check("load words", 8'h00, {7'h00, |{load_value, load_mask}});
    @(posedge mclk);
    #1;
    detect_clear = 1'b1;
    @(posedge mclk);
    #1;
    detect_clear = 1'b0;
    @(posedge mclk);
    #1;
    check("detect cleared", 8'h00, {7'h00, interface_detected_flag});
    print_verdict();
  end
endmodule  // test_serial_bus_master
